/* afh_top.sv */
`timescale 1ns/10ps
// Behaviour
// R1: While any issued function is unfinished, hold program advance and flag waiting.
// R2: Config bit 7 picks normal (0) or high-speed (1) handshake.
// R3: Normal mode: function ends when shared finish falls 1 to 0.
// R4: Outside logic drives the shared finish on bit 3 of its input byte.
// R5: High-speed: M bit 0, S 2, T 3, second aux 7 mill or 4 lathe.
// R6: Second and third M strobes on bits 4 and 5, finishes likewise.
// R7: Second and third M work only when multi-M bit 7 is set.
// R8: High-speed: finished when finish level equals strobe; requests toggle strobe.
module afh_top #(
    parameter bit LATHE_BUILD = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  aux_done_pins,
    input  wire logic [7:0]  extra_m_done_pins,
    output logic [7:0]       aux_strobe_pins,
    output logic [7:0]       extra_m_strobe_pins,
    output logic             advance_hold
);
    localparam int NC = afh_pkg::NUM_CHAN;

    logic [1:0]    rst_sync_q;
    logic          rst_n;
    logic [7:0]    aux_done_m_q;
    logic [7:0]    aux_done_q;
    logic [7:0]    xm_done_m_q;
    logic [7:0]    xm_done_q;
    logic [7:0]    cfg_q;
    logic [7:0]    multi_q;
    logic [NC-1:0] issue_q;
    logic          dp_wr_q;
    logic [7:0]    dp_addr_q;
    logic [31:0]   hrdata_q;
    logic [31:0]   rd_d;
    logic          addr_go;
    logic [NC-1:0] strobe;
    logic [NC-1:0] busy;
    logic [NC-1:0] done_fast;
    logic [NC-1:0] chan_en;
    logic          fast_sel;
    logic          multi_m_enable;
    logic          waiting;
    logic [7:0]    stb_mill;
    logic [7:0]    stb_lathe;
    logic [7:0]    stb_xm;
    logic          bus_idle_q;

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Finish levels come from the machine logic, asynchronous to us
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_done_m_q <= 8'h00;
            aux_done_q   <= 8'h00;
            xm_done_m_q  <= 8'h00;
            xm_done_q    <= 8'h00;
        end else if (ce) begin
            aux_done_m_q <= aux_done_pins;
            aux_done_q   <= aux_done_m_q;
            xm_done_m_q  <= extra_m_done_pins;
            xm_done_q    <= xm_done_m_q;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign addr_go   = hsel && htrans[1] && hready && ce;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 8'h00;
        end else if (ce) begin
            dp_wr_q   <= addr_go && hwrite;
            dp_addr_q <= haddr[7:0];
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        if (haddr[31:8] == 24'h00_0000) begin
            case (haddr[7:0])
                afh_pkg::CFG_OFS:        rd_d[7:0] = cfg_q;
                afh_pkg::MULTI_OFS:      rd_d[7:0] = multi_q;
                afh_pkg::DONE_MILL_OFS:  rd_d[7:0] = LATHE_BUILD ? 8'h00 : aux_done_q;
                afh_pkg::STB_MILL_OFS:   rd_d[7:0] = stb_mill;
                afh_pkg::DONE_LATHE_OFS: rd_d[7:0] = LATHE_BUILD ? aux_done_q : 8'h00;
                afh_pkg::STB_LATHE_OFS:  rd_d[7:0] = stb_lathe;
                afh_pkg::XM_DONE_OFS:    rd_d[7:0] = xm_done_q;
                afh_pkg::XM_STB_OFS:     rd_d[7:0] = stb_xm;
                afh_pkg::STATUS_OFS: begin
                    rd_d[0] = waiting;
                    rd_d[afh_pkg::STAT_BUSY_LSB +: NC] = busy;
                end
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end

    // Read data sampled at the address phase so it stands in the data phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_go && !hwrite) begin
            hrdata_q <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q   <= afh_pkg::CFG_RST;
            multi_q <= afh_pkg::MULTI_RST;
        end else if (ce && dp_wr_q) begin
            if (dp_addr_q == afh_pkg::CFG_OFS) begin
                cfg_q <= hwdata[7:0];
            end
            if (dp_addr_q == afh_pkg::MULTI_OFS) begin
                multi_q <= hwdata[7:0];
            end
        end
    end

    assign fast_sel       = cfg_q[afh_pkg::FAST_SEL_BIT];      // [R2]
    assign multi_m_enable = multi_q[afh_pkg::MULTI_M_BIT];     // [R7]

    // Issue word: one-cycle pulse; refused while a block still waits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            issue_q <= '0;
        end else if (ce) begin
            if (dp_wr_q && dp_addr_q == afh_pkg::ISSUE_OFS && !waiting) begin
                issue_q <= hwdata[NC-1:0] & chan_en;             // [R1] [R7]
            end else begin
                issue_q <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Function channels
    // ------------------------------------------------------------
    assign done_fast[afh_pkg::ISS_M]  = aux_done_q[afh_pkg::M_BIT];    // [R5]
    assign done_fast[afh_pkg::ISS_S]  = aux_done_q[afh_pkg::S_BIT];
    assign done_fast[afh_pkg::ISS_T]  = aux_done_q[afh_pkg::T_BIT];
    assign done_fast[afh_pkg::ISS_B]  = LATHE_BUILD ? aux_done_q[afh_pkg::B_BIT_LATHE]
                                                    : aux_done_q[afh_pkg::B_BIT_MILL];
    assign done_fast[afh_pkg::ISS_M2] = xm_done_q[afh_pkg::M2_BIT];    // [R6]
    assign done_fast[afh_pkg::ISS_M3] = xm_done_q[afh_pkg::M3_BIT];

    assign chan_en = {multi_m_enable, multi_m_enable, 4'hF};            // [R7]

    generate
        for (genvar i = 0; i < NC; i++) begin : g_chan
            afh_chan u_chan (
                .clk        (clk),
                .rst_n      (rst_n),
                .ce         (ce),
                .en         (chan_en[i]),
                .issue      (issue_q[i]),
                .fast       (fast_sel),
                .fin_shared (aux_done_q[afh_pkg::SHARED_FIN_BIT]),  // [R3]
                .done_fast  (done_fast[i]),
                .strobe     (strobe[i]),
                .busy       (busy[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Strobe pins and program advance
    // ------------------------------------------------------------
    always_comb begin
        stb_mill  = 8'h00;
        stb_lathe = 8'h00;
        stb_xm    = 8'h00;
        stb_mill[afh_pkg::M_BIT]        = strobe[afh_pkg::ISS_M];       // [R5]
        stb_mill[afh_pkg::S_BIT]        = strobe[afh_pkg::ISS_S];
        stb_mill[afh_pkg::T_BIT]        = strobe[afh_pkg::ISS_T];
        stb_mill[afh_pkg::B_BIT_MILL]   = strobe[afh_pkg::ISS_B];
        stb_lathe[afh_pkg::M_BIT]       = strobe[afh_pkg::ISS_M];
        stb_lathe[afh_pkg::S_BIT]       = strobe[afh_pkg::ISS_S];
        stb_lathe[afh_pkg::T_BIT]       = strobe[afh_pkg::ISS_T];
        stb_lathe[afh_pkg::B_BIT_LATHE] = strobe[afh_pkg::ISS_B];
        stb_xm[afh_pkg::M2_BIT]         = strobe[afh_pkg::ISS_M2];      // [R6]
        stb_xm[afh_pkg::M3_BIT]         = strobe[afh_pkg::ISS_M3];
        if (LATHE_BUILD) begin
            stb_mill = 8'h00;
        end else begin
            stb_lathe = 8'h00;
        end
    end

    assign aux_strobe_pins     = LATHE_BUILD ? stb_lathe : stb_mill;
    assign extra_m_strobe_pins = stb_xm;
    assign waiting             = |busy;                                  // [R1]
    assign advance_hold        = waiting;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_idle_q <= 1'b1;
        end else begin
            bus_idle_q <= !dp_wr_q;
        end
    end

    hold_on_issue_a: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        (ce && |issue_q) |=> advance_hold)
        else $error("issued function did not hold program advance");
    hold_cause_a: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        (ce && !advance_hold && issue_q == '0) |=> !advance_hold)
        else $error("advance held without an issued function");
    mode_select_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        (ce && issue_q[afh_pkg::ISS_M] && !fast_sel) |=> strobe[afh_pkg::ISS_M])
        else $error("normal mode request did not raise strobe");
    m_pin_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        aux_strobe_pins[afh_pkg::M_BIT] == strobe[afh_pkg::ISS_M] &&
        aux_strobe_pins[afh_pkg::T_BIT] == strobe[afh_pkg::ISS_T])
        else $error("strobe pin position wrong");
    b_pin_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        aux_strobe_pins[LATHE_BUILD ? afh_pkg::B_BIT_LATHE : afh_pkg::B_BIT_MILL]
            == strobe[afh_pkg::ISS_B])
        else $error("second aux strobe on wrong bit");
    xm_pin_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        extra_m_strobe_pins[5:4] == strobe[afh_pkg::ISS_M3:afh_pkg::ISS_M2] &&
        extra_m_strobe_pins[3:0] == 4'h0)
        else $error("extra M strobe on wrong bit");
    multi_off_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        (ce && !multi_m_enable) |=> extra_m_strobe_pins == 8'h00 && !busy[5] && !busy[4])
        else $error("extra M active while disabled");
    refuse_busy_a: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        (ce && waiting && !bus_idle_q) |=> issue_q == '0)
        else $error("issue taken while waiting for finish");
endmodule

/* afh_pkg.sv */
package afh_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_OFS        = 8'h00;
    localparam logic [7:0] MULTI_OFS      = 8'h04;
    localparam logic [7:0] DONE_MILL_OFS  = 8'h08;
    localparam logic [7:0] STB_MILL_OFS   = 8'h0C;
    localparam logic [7:0] DONE_LATHE_OFS = 8'h10;
    localparam logic [7:0] STB_LATHE_OFS  = 8'h14;
    localparam logic [7:0] XM_DONE_OFS    = 8'h18;
    localparam logic [7:0] XM_STB_OFS     = 8'h1C;
    localparam logic [7:0] ISSUE_OFS      = 8'h20;
    localparam logic [7:0] STATUS_OFS     = 8'h24;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int FAST_SEL_BIT    = 7;
    localparam int MULTI_M_BIT     = 7;
    localparam int SHARED_FIN_BIT  = 3;
    localparam int M_BIT           = 0;
    localparam int S_BIT           = 2;
    localparam int T_BIT           = 3;
    localparam int B_BIT_MILL      = 7;
    localparam int B_BIT_LATHE     = 4;
    localparam int M2_BIT          = 4;
    localparam int M3_BIT          = 5;
    localparam int STAT_BUSY_LSB   = 8;
    localparam int NUM_CHAN        = 6;
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [7:0] MULTI_RST = 8'h00;

    // Issue register: one bit per function
    localparam int ISS_M  = 0;
    localparam int ISS_S  = 1;
    localparam int ISS_T  = 2;
    localparam int ISS_B  = 3;
    localparam int ISS_M2 = 4;
    localparam int ISS_M3 = 5;

    typedef enum logic [3:0] {
        CH_IDLE = 4'h1,
        CH_ACK  = 4'h2,
        CH_FALL = 4'h4,
        CH_FAST = 4'h8
    } afh_chan_st_t;

endpackage

/* afh_chan.sv */
`timescale 1ns/10ps
module afh_chan (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic en,
    input  wire logic issue,
    input  wire logic fast,
    input  wire logic fin_shared,
    input  wire logic done_fast,
    output logic      strobe,
    output logic      busy
);
    afh_pkg::afh_chan_st_t st_q;
    logic                  strobe_q;

    // ------------------------------------------------------------
    // Handshake sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q     <= afh_pkg::CH_IDLE;
            strobe_q <= 1'b0;
        end else if (ce) begin
            if (!en) begin
                st_q     <= afh_pkg::CH_IDLE;
                strobe_q <= 1'b0;
            end else begin
                case (st_q)
                    afh_pkg::CH_IDLE: begin
                        if (issue && fast) begin
                            st_q     <= afh_pkg::CH_FAST;
                            strobe_q <= ~strobe_q;                 // [R8]
                        end else if (issue) begin
                            st_q     <= afh_pkg::CH_ACK;
                            strobe_q <= 1'b1;
                        end
                    end
                    afh_pkg::CH_ACK: begin
                        if (fin_shared) begin
                            st_q     <= afh_pkg::CH_FALL;
                            strobe_q <= 1'b0;
                        end
                    end
                    afh_pkg::CH_FALL: begin
                        if (!fin_shared) begin
                            st_q <= afh_pkg::CH_IDLE;              // [R3]
                        end
                    end
                    afh_pkg::CH_FAST: begin
                        if (done_fast == strobe_q) begin
                            st_q <= afh_pkg::CH_IDLE;              // [R8]
                        end
                    end
                    default: st_q <= afh_pkg::CH_IDLE;
                endcase
            end
        end
    end

    assign strobe = strobe_q;
    assign busy   = (st_q != afh_pkg::CH_IDLE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence fin_seen_s;
        ce && en && st_q == afh_pkg::CH_ACK && fin_shared;
    endsequence
    sequence fin_low_s;
        ce && en && st_q == afh_pkg::CH_FALL && !fin_shared;
    endsequence

    normal_fall_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        fin_seen_s |=> (st_q == afh_pkg::CH_FALL) && !strobe_q && busy)
        else $error("normal handshake did not drop strobe on finish");
    normal_end_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        fin_low_s |=> !busy)
        else $error("normal handshake did not end on finish fall");
    fast_match_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        (ce && en && st_q == afh_pkg::CH_FAST && done_fast == strobe_q) |=> !busy)
        else $error("fast handshake did not end on matching finish");
    fast_toggle_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        (ce && en && !busy && issue && fast) |=> (strobe != $past(strobe)) && busy)
        else $error("fast request did not toggle strobe");
endmodule

/* afh_plc_model.sv */
`timescale 1ns/10ps
module afh_plc_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       fast,
    input  wire logic       slow,
    input  wire logic [7:0] strobe_pins,
    input  wire logic [7:0] xm_strobe_pins,
    output logic [7:0]      done_pins,
    output logic [7:0]      xm_done_pins
);
    // ------------------------------------------------------------
    // Ladder-side finish logic
    // ------------------------------------------------------------
    logic [7:0] tgt_aux;
    logic [7:0] tgt_xm;
    logic [3:0] wait_q;

    always_comb begin
        tgt_aux = 8'h00;
        tgt_xm  = 8'h00;
        if (fast) begin
            // M, S, T and mill second aux echo their strobe levels
            tgt_aux = strobe_pins & 8'h8D;
            tgt_xm  = xm_strobe_pins & 8'h30;
        end else begin
            // Shared finish follows any raised strobe
            tgt_aux[3] = (|strobe_pins) | (|xm_strobe_pins);
        end
    end

    // Slow mode stretches every answer, like a long ladder scan
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_pins    <= 8'h00;
            xm_done_pins <= 8'h00;
            wait_q       <= 4'h0;
        end else if ({tgt_aux, tgt_xm} != {done_pins, xm_done_pins}) begin
            if (wait_q >= (slow ? 4'hA : 4'h0)) begin
                done_pins    <= tgt_aux;
                xm_done_pins <= tgt_xm;
                wait_q       <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end else begin
            wait_q <= 4'h0;
        end
    end
endmodule

/* tb_afh_top.sv */
`timescale 1ns/10ps
module tb_afh_top;
    logic        clk          = 1'b0;
    logic        reset_n      = 1'b0;
    logic        hsel         = 1'b0;
    logic [31:0] haddr        = 32'h0;
    logic [1:0]  htrans       = 2'h0;
    logic        hwrite       = 1'b0;
    logic [31:0] hwdata       = 32'h0;
    logic        fast         = 1'b0;
    logic        slow         = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        advance_hold;
    logic [7:0]  done_pins;
    logic [7:0]  xm_done_pins;
    logic [7:0]  strobe_pins;
    logic [7:0]  xm_strobe_pins;
    logic [7:0]  exp_stb;
    logic [31:0] rd;
    int          error_cnt    = 0;
    int          tests_run    = 0;
    int          cyc          = 0;

    always #2 clk = ~clk;

    afh_top #(.LATHE_BUILD(1'b0)) u_afh_top (
        .clk(clk), .reset_n(reset_n), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .aux_done_pins(done_pins), .extra_m_done_pins(xm_done_pins),
        .aux_strobe_pins(strobe_pins), .extra_m_strobe_pins(xm_strobe_pins),
        .advance_hold(advance_hold));

    afh_plc_model u_afh_plc_model (
        .clk(clk), .rst_n(reset_n), .fast(fast), .slow(slow),
        .strobe_pins(strobe_pins), .xm_strobe_pins(xm_strobe_pins),
        .done_pins(done_pins), .xm_done_pins(xm_done_pins));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Mill strobe position of function i (M, S, T, second aux)
    function automatic logic [7:0] pos_of(input int i);
        case (i)
            0:       pos_of = 8'h01 << afh_pkg::M_BIT;
            1:       pos_of = 8'h01 << afh_pkg::S_BIT;
            2:       pos_of = 8'h01 << afh_pkg::T_BIT;
            default: pos_of = 8'h01 << afh_pkg::B_BIT_MILL;
        endcase
    endfunction

    task automatic print_verdict;
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, addr};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? wd : 32'h0;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        ahb(1'b1, addr, wd);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        ahb(1'b0, addr, 32'h0);
        check(rd, exp);
    endtask

    // Strobe is visible one edge after the write data phase ends
    task automatic issue(input logic [7:0] bits);
        wr(afh_pkg::ISSUE_OFS, {24'h0, bits});
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (advance_hold !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        check(32'(advance_hold), 32'h0);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict;
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(afh_pkg::CFG_OFS, 32'h0);
        rd_chk(afh_pkg::MULTI_OFS, 32'h0);
        rd_chk(8'h3C, 32'h0);
        check(32'(hresp), 32'h0);
        check(32'(hreadyout), 32'h1);
        slow <= 1'b1;
        issue(8'h01 << afh_pkg::ISS_M);
        check(32'(strobe_pins), 32'h01);
        check(32'(advance_hold), 32'h1);
        rd_chk(afh_pkg::STATUS_OFS, 32'h101);
        // Second request while M still waits must be refused
        issue(8'h01 << afh_pkg::ISS_S);
        check(32'(strobe_pins), 32'h01);
        check(32'(advance_hold), 32'h1);
        while (strobe_pins[0] !== 1'b0 && cyc < 19000) @(posedge clk);
        #1;
        check(32'(done_pins), 32'h08);
        check(32'(advance_hold), 32'h1);
        wait_idle();
        issue(8'h03);
        check(32'(strobe_pins), 32'h05);
        wait_idle();
        check(32'(strobe_pins), 32'h00);
        wr(afh_pkg::CFG_OFS, 32'h80);
        fast <= 1'b1;
        rd_chk(afh_pkg::CFG_OFS, 32'h80);
        exp_stb = 8'h00;
        // Two rounds so each strobe toggles up and back down
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 4; i++) begin
                issue(8'h01 << i);
                exp_stb = exp_stb ^ pos_of(i);
                check(32'(strobe_pins), 32'(exp_stb));
                check(32'(advance_hold), 32'h1);
                wait_idle();
                rd_chk(afh_pkg::DONE_MILL_OFS, 32'(exp_stb));
            end
        end
        wr(afh_pkg::STB_MILL_OFS, 32'hFF);
        rd_chk(afh_pkg::STB_MILL_OFS, 32'h0);
        issue(8'h01 << afh_pkg::ISS_M2);
        check(32'(xm_strobe_pins), 32'h0);
        check(32'(advance_hold), 32'h0);
        wr(afh_pkg::MULTI_OFS, 32'h80);
        rd_chk(afh_pkg::MULTI_OFS, 32'h80);
        issue(8'h01 << afh_pkg::ISS_M2);
        check(32'(xm_strobe_pins), 32'h10);
        wait_idle();
        issue(8'h01 << afh_pkg::ISS_M3);
        check(32'(xm_strobe_pins), 32'h30);
        wait_idle();
        rd_chk(afh_pkg::XM_DONE_OFS, 32'h30);
        print_verdict;
    end
endmodule
